/* include/fsec_pkg.sv */
// package: constants, register map and carrier types for the security/option block
package fsec_pkg;

   // bus geometry
   localparam int unsigned ADR_W      = 18;
   localparam int unsigned IDX_W      = 16;
   localparam int unsigned DAT_W      = 32;
   localparam int unsigned SEL_W      = 4;

   // register indices (byte address = index * 4)
   localparam logic [15:0] IDX_OPTION_WORK  = 16'h1821;
   localparam logic [15:0] IDX_PROT_WORK    = 16'h1824;
   localparam logic [15:0] IDX_NV_PROT      = 16'hFFBD;
   localparam logic [15:0] IDX_NV_OPTION    = 16'hFFBF;
   localparam logic [15:0] IDX_KEY_LO       = 16'h1830;
   localparam logic [15:0] IDX_KEY_HI       = 16'h1831;
   localparam logic [15:0] IDX_KEY_CTRL     = 16'h1832;
   localparam logic [15:0] IDX_SEC_STATUS   = 16'h1833;

   // nonvolatile area byte addresses in flash
   localparam logic [15:0] NV_KEY_BASE      = 16'hFFB0;
   localparam logic [15:0] NV_PROT_ADDR     = 16'hFFBD;
   localparam logic [15:0] NV_OPTION_ADDR   = 16'hFFBF;
   localparam logic [3:0]  NV_LOAD_COUNT    = 4'hA;
   localparam logic [3:0]  NV_KEY_FIRST     = 4'h2;

   // option byte fields
   localparam int unsigned OPT_BACKDOOR_KEY_ENABLE_BIT    = 7;
   localparam logic [7:0]  OPT_MASK         = 8'hC3;
   localparam logic [7:0]  PROT_MASK        = 8'hF8;
   localparam logic [1:0]  SEC_UNSECURED    = 2'b10;

   // key control and status bit positions
   localparam int unsigned KCTRL_GO_BIT     = 0;
   localparam int unsigned STAT_SECURED     = 0;
   localparam int unsigned STAT_KEY_OPEN    = 1;
   localparam int unsigned STAT_ERASE_OPEN  = 2;
   localparam int unsigned STAT_KEY_FAIL    = 3;
   localparam int unsigned STAT_LOADED      = 4;
   localparam int unsigned STAT_ERASED      = 5;

   // reset values
   localparam logic [7:0]  OPTION_RESET     = 8'h00;
   localparam logic [7:0]  PROT_RESET       = 8'h00;
   localparam logic [15:0] STACK_PTR_RESET  = 16'h00FF;

   // on-chip ram geometry
   localparam int unsigned RAM_AW           = 10;
   localparam int unsigned RAM_DEPTH        = 1024;

   typedef struct packed {
      logic [7:0]  prot;
      logic [7:0]  option;
      logic [63:0] key;
   } nv_image_t;

   typedef struct packed {
      logic              we;
      logic [RAM_AW-1:0] addr;
      logic [7:0]        wdata;
      logic              from_debug;
      logic              from_nonsecure;
   } ram_req_t;

endpackage : fsec_pkg

/* core/fsec_ram.sv */
// file: retained on-chip ram, contents never reset, registered read data
`timescale 1ns/1ps
`default_nettype none
module fsec_ram
   import fsec_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              en,
   input  wire logic              we,
   input  wire logic [RAM_AW-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic      [7:0]        rdata
);

   logic [7:0] mem [RAM_DEPTH];

   // no reset on the array: contents survive wait, shallow stops and warm resets
   always_ff @(posedge clk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (en && !we) begin
         rdata <= mem[addr];
      end
   end

endmodule : fsec_ram
`default_nettype wire

/* core/fsec_nv_loader.sv */
// file: reset-time fetch of protection, option and key bytes from the flash nonvolatile area
`timescale 1ns/1ps
`default_nettype none
module fsec_nv_loader
   import fsec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   output logic             rd_req,
   output logic      [15:0] rd_addr,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_valid,
   output nv_image_t        image,
   output logic             done
);

   typedef enum logic [1:0] {
      ST_FETCH = 2'b01,
      ST_DONE  = 2'b10
   } ld_state_t;

   ld_state_t state_reg;
   ld_state_t state_next;
   logic [3:0] cnt_reg;
   nv_image_t  image_reg;

   wire        last_byte = (cnt_reg == NV_LOAD_COUNT - 4'h1);
   wire        take      = (state_reg == ST_FETCH) && rd_valid;
   wire [3:0]  key_idx   = cnt_reg - NV_KEY_FIRST;
   wire [15:0] key_addr  = NV_KEY_BASE + {12'h000, key_idx};

   // protection first, then option, then the eight key bytes
   assign rd_addr = (cnt_reg == 4'h0) ? NV_PROT_ADDR :
                    (cnt_reg == 4'h1) ? NV_OPTION_ADDR : key_addr;
   assign rd_req  = (state_reg == ST_FETCH);
   assign image   = image_reg;
   assign done    = (state_reg == ST_DONE);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_FETCH: if (take && last_byte) state_next = ST_DONE;
         ST_DONE:  state_next = ST_DONE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_FETCH;
         cnt_reg   <= 4'h0;
         image_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (take) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == 4'h0) image_reg.prot <= rd_data;
            else if (cnt_reg == 4'h1) image_reg.option <= rd_data;
            else image_reg.key[8*(7-key_idx[2:0]) +: 8] <= rd_data;
         end
      end
   end

endmodule : fsec_nv_loader
`default_nettype wire

/* core/flash_security_option_loader.sv */
// file: flash security, option loading, backdoor key gate and secure ram access
//
// Behaviour
// - every reset copies nonvolatile protection and option bytes into working registers
// - with key enable set, an eight-byte flash key may lift security for now
// - key accepted only from code in secure memory; debug attempts are ignored
// - key enable cleared disables the key compare entirely
// - without key, only mass erase then passing blank check lifts security
// - security field code 1:0 means unsecured; software programs it to stay open
// - ram keeps its contents in wait and the two shallower stop modes
// - ram uninitialised at power-on or deepest stop; other resets leave it
// - reset sets the processor stack pointer to 00FF
// - while secured, ram refuses debug port and non-secure code
`timescale 1ns/1ps
`default_nettype none
module flash_security_option_loader
   import fsec_pkg::*;
(
   input  wire logic             CLK,
   input  wire logic             RSTN,
   // classic wishbone slave
   input  wire logic             WB_CYC_I,
   input  wire logic             WB_STB_I,
   input  wire logic             WB_WE_I,
   input  wire logic [ADR_W-1:0] WB_ADR_I,
   input  wire logic [SEL_W-1:0] WB_SEL_I,
   input  wire logic [DAT_W-1:0] WB_DAT_I,
   output logic      [DAT_W-1:0] WB_DAT_O,
   output logic                  WB_ACK_O,
   // qualifiers of the current bus cycle's origin
   input  wire logic             DBG_ACCESS,
   input  wire logic             EXEC_SECURE,
   // flash nonvolatile read port
   output logic                  NV_RD_REQ,
   output logic      [15:0]      NV_RD_ADDR,
   input  wire logic [7:0]       NV_RD_DATA,
   input  wire logic             NV_RD_VALID,
   // flash command engine events
   input  wire logic             MASS_ERASE_DONE,
   input  wire logic             BLANK_CHECK_PASS,
   // ram access port
   input  wire logic             RAM_REQ_VALID,
   input  wire ram_req_t         RAM_REQ,
   output logic      [7:0]       RAM_RDATA,
   output logic                  RAM_ACK,
   output logic                  RAM_DENIED,
   // status towards the core and debug port
   output logic                  SECURED,
   output logic      [7:0]       PROT_WORKING,
   output logic      [15:0]      STACK_PTR_INIT
);

   ////////////////////////////////////////////////////////////////////////////
   // nonvolatile image load

   nv_image_t  nv_image;
   logic       nv_done;

   fsec_nv_loader u_loader (
      .clk      (CLK),
      .rst_n    (RSTN),
      .rd_req   (NV_RD_REQ),
      .rd_addr  (NV_RD_ADDR),
      .rd_data  (NV_RD_DATA),
      .rd_valid (NV_RD_VALID),
      .image    (nv_image),
      .done     (nv_done)
   );

   // copy into working registers once, the cycle the image completes
   logic       loaded_reg;
   logic [7:0] option_reg;
   logic [7:0] prot_reg;
   logic [7:0] nv_prot_reg;
   logic [7:0] nv_option_reg;
   logic [63:0] nv_key_reg;

   wire load_now = nv_done && !loaded_reg;

   ////////////////////////////////////////////////////////////////////////////
   // wishbone decode

   logic              ack_reg;
   logic [DAT_W-1:0]  dat_reg;

   wire [IDX_W-1:0] idx      = WB_ADR_I[ADR_W-1:2];
   wire             req      = WB_CYC_I && WB_STB_I;
   wire             req_new  = req && !ack_reg;
   // writes land on the edge where the master samples ack
   wire             wr_take  = req && ack_reg && WB_WE_I;

   wire hit_option   = (idx == IDX_OPTION_WORK);
   wire hit_prot     = (idx == IDX_PROT_WORK);
   wire hit_nv_prot  = (idx == IDX_NV_PROT);
   wire hit_nv_opt   = (idx == IDX_NV_OPTION);
   wire hit_key_lo   = (idx == IDX_KEY_LO);
   wire hit_key_hi   = (idx == IDX_KEY_HI);
   wire hit_key_ctrl = (idx == IDX_KEY_CTRL);
   wire hit_status   = (idx == IDX_SEC_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // security state

   logic       key_open_reg;
   logic       erase_open_reg;
   logic       erased_reg;
   logic       key_fail_reg;
   logic [63:0] key_entry_reg;

   wire [1:0] sec_field  = option_reg[1:0];
   wire       backdoor_key_enable      = option_reg[OPT_BACKDOOR_KEY_ENABLE_BIT];
   wire       field_open = (sec_field == SEC_UNSECURED);
   // until the image is in, the part is held secured
   wire       secured    = !loaded_reg ||
                           (!field_open && !key_open_reg && !erase_open_reg);

   // a key may be presented only by secure code, never over the debug port
   wire       key_source_ok = EXEC_SECURE && !DBG_ACCESS;
   // one failed compare locks the key path until the next reset
   wire       key_allowed   = backdoor_key_enable && loaded_reg && !key_fail_reg;
   wire       key_write_ok  = wr_take && key_source_ok && key_allowed;
   wire       key_go        = key_write_ok && hit_key_ctrl &&
                              WB_SEL_I[0] && WB_DAT_I[KCTRL_GO_BIT];
   wire       key_match     = (key_entry_reg == nv_key_reg);

   // writes to the working protection register are refused while secured
   wire       prot_write    = wr_take && hit_prot && WB_SEL_I[0] && !secured;

   ////////////////////////////////////////////////////////////////////////////
   // read mux

   wire [7:0] status_byte = {2'b00,
                             erased_reg,
                             loaded_reg,
                             key_fail_reg,
                             erase_open_reg,
                             key_open_reg,
                             secured};

   wire [DAT_W-1:0] rd_mux =
      hit_option  ? {24'h00_0000, option_reg & OPT_MASK} :
      hit_prot    ? {24'h00_0000, prot_reg & PROT_MASK} :
      hit_nv_prot ? {24'h00_0000, nv_prot_reg & PROT_MASK} :
      hit_nv_opt  ? {24'h00_0000, nv_option_reg & OPT_MASK} :
      hit_status  ? {24'h00_0000, status_byte} :
                    32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req_new;
         if (req_new && !WB_WE_I) begin
            dat_reg <= rd_mux;
         end
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = dat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // working registers

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         loaded_reg    <= 1'b0;
         option_reg    <= OPTION_RESET;
         prot_reg      <= PROT_RESET;
         nv_prot_reg   <= PROT_RESET;
         nv_option_reg <= OPTION_RESET;
         nv_key_reg    <= 64'h0000_0000_0000_0000;
      end else begin
         if (load_now) begin
            loaded_reg    <= 1'b1;
            option_reg    <= nv_image.option;
            prot_reg      <= nv_image.prot;
            nv_prot_reg   <= nv_image.prot;
            nv_option_reg <= nv_image.option;
            nv_key_reg    <= nv_image.key;
         end else if (prot_write) begin
            prot_reg <= WB_DAT_I[7:0] & PROT_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // key entry, one generate lane per bus byte lane, each writing a low and a high key byte

   genvar lane;
   generate
      for (lane = 0; lane < SEL_W; lane++) begin : g_key_lane
         always_ff @(posedge CLK) begin
            if (!RSTN) begin
               key_entry_reg[8*lane +: 8]      <= 8'h00;
               key_entry_reg[32 + 8*lane +: 8] <= 8'h00;
            end else if (key_write_ok && WB_SEL_I[lane]) begin
               if (hit_key_lo) begin
                  key_entry_reg[8*lane +: 8] <= WB_DAT_I[8*lane +: 8];
               end
               if (hit_key_hi) begin
                  key_entry_reg[32 + 8*lane +: 8] <= WB_DAT_I[8*lane +: 8];
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // unlock paths

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         key_open_reg   <= 1'b0;
         key_fail_reg   <= 1'b0;
         erase_open_reg <= 1'b0;
         erased_reg     <= 1'b0;
      end else begin
         if (key_go) begin
            if (key_match) begin
               key_open_reg <= 1'b1;
            end else begin
               key_fail_reg <= 1'b1;
            end
         end
         // erase must come no later than the blank check, which then confirms it
         if (MASS_ERASE_DONE) begin
            erased_reg <= 1'b1;
         end
         if (BLANK_CHECK_PASS && (erased_reg || MASS_ERASE_DONE)) begin
            erase_open_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // secure ram access

   logic ram_ack_reg;
   logic ram_denied_reg;

   // a denied access never reaches the array, so secret data stays put
   wire ram_blocked = secured &&
                      (RAM_REQ.from_debug || RAM_REQ.from_nonsecure);
   wire ram_en      = RAM_REQ_VALID && !ram_blocked;

   // array has no reset and no clear path, so any reset leaves it as it was
   fsec_ram u_ram (
      .clk   (CLK),
      .en    (ram_en),
      .we    (RAM_REQ.we),
      .addr  (RAM_REQ.addr),
      .wdata (RAM_REQ.wdata),
      .rdata (RAM_RDATA)
   );

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         ram_ack_reg    <= 1'b0;
         ram_denied_reg <= 1'b0;
      end else begin
         ram_ack_reg    <= ram_en;
         ram_denied_reg <= RAM_REQ_VALID && ram_blocked;
      end
   end

   assign RAM_ACK    = ram_ack_reg;
   assign RAM_DENIED = ram_denied_reg;

   ////////////////////////////////////////////////////////////////////////////
   // status outputs

   logic [15:0] sp_init_reg;
   logic        secured_reg;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         sp_init_reg <= STACK_PTR_RESET;
         secured_reg <= 1'b1;
      end else begin
         secured_reg <= secured;
      end
   end

   assign STACK_PTR_INIT = sp_init_reg;
   assign SECURED        = secured_reg;
   assign PROT_WORKING   = prot_reg;

endmodule : flash_security_option_loader
`default_nettype wire

/* verif/fsec_chk.sv */
// port checker for the security and option loader
`timescale 1ns/1ps
`default_nettype none
module fsec_chk
   import fsec_pkg::*;
(
   input wire logic             CLK,
   input wire logic             RSTN,
   input wire logic             WB_CYC_I,
   input wire logic             WB_STB_I,
   input wire logic             WB_WE_I,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic             WB_ACK_O,
   input wire logic             DBG_ACCESS,
   input wire logic             EXEC_SECURE,
   input wire logic             NV_RD_REQ,
   input wire logic [15:0]      NV_RD_ADDR,
   input wire logic             NV_RD_VALID,
   input wire logic             RAM_REQ_VALID,
   input wire ram_req_t         RAM_REQ,
   input wire logic             RAM_ACK,
   input wire logic             RAM_DENIED,
   input wire logic             SECURED,
   input wire logic [15:0]      STACK_PTR_INIT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   bus_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("bus ack held too long");
   stack_init_a: assert property (STACK_PTR_INIT == 16'h00FF)
      else $error("stack pointer init wrong");
   reset_secure_a: assert property ($rose(RSTN) |-> SECURED)
      else $error("not secured after reset");
   nv_first_a: assert property ($rose(RSTN) |-> NV_RD_REQ && NV_RD_ADDR == 16'hFFBD)
      else $error("load does not start at protection byte");
   nv_order_a: assert property (NV_RD_REQ && NV_RD_VALID && NV_RD_ADDR == 16'hFFBD
      |=> NV_RD_ADDR == 16'hFFBF) else $error("option byte not fetched second");
   ram_deny_a: assert property (RAM_REQ_VALID && SECURED
      && (RAM_REQ.from_debug || RAM_REQ.from_nonsecure) |=> RAM_DENIED && !RAM_ACK)
      else $error("secured ram not refused");
   ram_grant_a: assert property (RAM_REQ_VALID && (!SECURED
      || !(RAM_REQ.from_debug || RAM_REQ.from_nonsecure)) |=> RAM_ACK && !RAM_DENIED)
      else $error("ram access not granted");
   key_guard_a: assert property (WB_ACK_O && WB_WE_I && WB_ADR_I[17:2] == 16'h1832
      && (DBG_ACCESS || !EXEC_SECURE) && SECURED |=> SECURED [*3])
      else $error("key from debug or nonsecure code unlocked");
endmodule : fsec_chk
`default_nettype wire

/* verif/nv_model.sv */
// flash nonvolatile area answering the loader's byte reads
`timescale 1ns/1ps
`default_nettype none
module nv_model
   import fsec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        req,
   input  wire logic [15:0] addr,
   input  wire nv_image_t   img,
   input  wire logic        slow,
   output logic      [7:0]  data,
   output logic             valid
);
   logic [1:0] wait_reg;
   logic [7:0] byte_sel;

   // key byte at the lowest address sits in the top lane
   assign byte_sel = (addr == NV_PROT_ADDR) ? img.prot :
                     (addr == NV_OPTION_ADDR) ? img.option :
                     img.key[(7 - addr[2:0]) * 8 + 7 -: 8];

   always_ff @(posedge clk) begin
      valid <= 1'b0;
      // released lines toggle so a stale byte is never mistaken for data
      data  <= ~data;
      if (!rst_n) begin
         data     <= 8'h00;
         wait_reg <= 2'h0;
      end else if (req && !valid && wait_reg == (slow ? 2'h3 : 2'h0)) begin
         valid    <= 1'b1;
         data     <= byte_sel;
         wait_reg <= 2'h0;
      end else if (req && !valid) begin
         wait_reg <= wait_reg + 2'h1;
      end
   end
endmodule : nv_model
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the security and option loader
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import fsec_pkg::*;
;
   localparam logic [63:0] RAM_NO = {32'h0000_0300, 32'h0000_0200};
   localparam logic [63:0] RAM_WR = {32'h0000_0300, 32'h0000_0100};
   logic        CLK, RSTN, cyc, stb, we, dbg, exsec, erase, blank, rvalid, slow;
   logic        ack, nv_req, nv_valid, ram_ack, ram_den, secured;
   logic [17:0] adr;
   logic [31:0] wdat, dat_o, rdat, lfsr, ra;
   logic [15:0] nv_addr, sp;
   logic [7:0]  nv_data, ram_rd, prot_w;
   logic [63:0] key;
   logic [63:0] wq[$];
   logic [63:0] rq[$];
   ram_req_t    rreq;
   nv_image_t   img;
   int          num_errors, n_compared, cycles;

   flash_security_option_loader DUT (
      .CLK(CLK), .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .DBG_ACCESS(dbg), .EXEC_SECURE(exsec), .NV_RD_REQ(nv_req), .NV_RD_ADDR(nv_addr),
      .NV_RD_DATA(nv_data), .NV_RD_VALID(nv_valid), .MASS_ERASE_DONE(erase),
      .BLANK_CHECK_PASS(blank), .RAM_REQ_VALID(rvalid), .RAM_REQ(rreq), .RAM_RDATA(ram_rd),
      .RAM_ACK(ram_ack), .RAM_DENIED(ram_den), .SECURED(secured), .PROT_WORKING(prot_w),
      .STACK_PTR_INIT(sp));
   nv_model u_nv (.clk(CLK), .rst_n(RSTN), .req(nv_req), .addr(nv_addr), .img(img),
      .slow(slow), .data(nv_data), .valid(nv_valid));

   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   task automatic stop_test;
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   // upper half of the note is a care mask, so unknown bits only pass where ignored
   task automatic chk(input logic [63:0] me, input logic [31:0] g);
      n_compared++;
      if ((g & me[63:32]) !== me[31:0]) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g & me[63:32], me[31:0]);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [15:0] i, input logic [31:0] d,
                     input logic [63:0] me);
      @(posedge CLK);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {i, 2'b00};
      wdat <= d;
      if (!w) wq.push_back(me);
      do @(posedge CLK); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic rd(input logic [15:0] i, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, i, 32'h0000_0000, {m, e});
   endtask : rd

   task automatic sec(input logic e);
      rd(IDX_SEC_STATUS, 32'h0000_0001, {31'h0, e});
   endtask : sec

   task automatic ram(input logic w, input logic [9:0] a, input logic [7:0] d,
                      input logic fd, input logic fn, input logic [63:0] me);
      @(posedge CLK);
      rvalid <= 1'b1;
      rreq   <= '{w, a, d, fd, fn};
      rq.push_back(me);
      @(posedge CLK);
      rvalid <= 1'b0;
      @(posedge CLK);
   endtask : ram

   task automatic boot(input logic [7:0] o, input logic [7:0] p, input logic s);
      img  <= '{p, o, key};
      slow <= rnd() > 32'h7FFF_FFFF;
      RSTN <= 1'b0;
      repeat (5) @(posedge CLK);
      RSTN <= 1'b1;
      do wb(1'b0, IDX_SEC_STATUS, 32'h0000_0000, 64'h0); while (rdat[STAT_LOADED] !== 1'b1);
      chk({32'h0000_FFFF, 32'h0000_00FF}, {16'h0, sp});
      chk({32'h0000_00F8, 24'h0, p & PROT_MASK}, {24'h0, prot_w});
      rd(IDX_OPTION_WORK, 32'h0000_00FF, {24'h0, o & OPT_MASK});
      rd(IDX_PROT_WORK, 32'h0000_00FF, {24'h0, p & PROT_MASK});
      sec(s);
   endtask : boot

   task automatic try_key(input logic [63:0] k, input logic d, input logic s);
      dbg   <= d;
      exsec <= s;
      wb(1'b1, IDX_KEY_LO, k[31:0], 64'h0);
      wb(1'b1, IDX_KEY_HI, k[63:32], 64'h0);
      wb(1'b1, IDX_KEY_CTRL, 32'h0000_0001, 64'h0);
      dbg   <= 1'b0;
      exsec <= 1'b1;
      repeat (2) @(posedge CLK);
   endtask : try_key
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge CLK) begin
      cycles++;
      if (ack === 1'b1 && we === 1'b0) chk(wq.pop_front(), dat_o);
      if (ram_ack === 1'b1 || ram_den === 1'b1) chk(rq.pop_front(), {22'h0, ram_den, ram_ack, ram_rd});
      if (cycles > 20000) begin
         num_errors++;
         stop_test();
      end
   end

   initial begin
      {RSTN, cyc, stb, we, dbg, erase, blank, rvalid, slow} = '0;
      exsec = 1'b1;
      adr = '0;
      wdat = '0;
      rreq = '0;
      img = '0;
      lfsr = 32'h0000_e528;
      key = {rnd(), rnd()};
      ra = rnd();
      boot({2'b10, ra[5:2], 2'b00}, ra[15:8], 1'b1);
      ram(1'b1, ra[25:16], ra[7:0], 1'b1, 1'b0, RAM_NO);
      ram(1'b0, ra[25:16], 8'h00, 1'b0, 1'b1, RAM_NO);
      ram(1'b1, ra[25:16], ra[7:0], 1'b0, 1'b0, RAM_WR);
      ram(1'b0, ra[25:16], 8'h00, 1'b0, 1'b0, {32'h0000_03FF, 22'h0, 2'b01, ra[7:0]});
      wb(1'b1, IDX_PROT_WORK, 32'h0000_00FF, 64'h0);
      rd(IDX_PROT_WORK, 32'h0000_00FF, {24'h0, ra[15:8] & PROT_MASK});
      try_key(key, 1'b1, 1'b1);
      sec(1'b1);
      try_key(key, 1'b0, 1'b0);
      sec(1'b1);
      try_key(key, 1'b0, 1'b1);
      sec(1'b0);
      ram(1'b0, ra[25:16], 8'h00, 1'b1, 1'b0, {32'h0000_03FF, 22'h0, 2'b01, ra[7:0]});
      boot({2'b11, ra[5:2], 2'b01}, ra[15:8], 1'b1);
      try_key(key ^ 64'h1, 1'b0, 1'b1);
      rd(IDX_SEC_STATUS, 32'h0000_0009, 32'h0000_0009);
      boot({2'b01, ra[5:2], 2'b01}, ra[15:8], 1'b1);
      try_key(key, 1'b0, 1'b1);
      sec(1'b1);
      @(posedge CLK);
      erase <= 1'b1;
      @(posedge CLK);
      erase <= 1'b0;
      blank <= 1'b1;
      @(posedge CLK);
      blank <= 1'b0;
      repeat (2) @(posedge CLK);
      sec(1'b0);
      ram(1'b0, ra[25:16], 8'h00, 1'b1, 1'b0, {32'h0000_03FF, 22'h0, 2'b01, ra[7:0]});
      for (int i = 0; i < 4; i++) begin
         ra = rnd();
         boot({1'b1, ra[6], 4'h0, i[1:0] + 2'h3}, ra[15:8], i != 3);
      end
      wb(1'b1, IDX_PROT_WORK, ra, 64'h0);
      rd(IDX_PROT_WORK, 32'h0000_00FF, {24'h0, ra[7:0] & PROT_MASK});
      rd(16'h0123, 32'hFFFF_FFFF, 32'h0000_0000);
      stop_test();
   end
endmodule : tb_top

bind flash_security_option_loader fsec_chk u_chk (
   .CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .DBG_ACCESS(DBG_ACCESS),
   .EXEC_SECURE(EXEC_SECURE), .NV_RD_REQ(NV_RD_REQ), .NV_RD_ADDR(NV_RD_ADDR),
   .NV_RD_VALID(NV_RD_VALID), .RAM_REQ_VALID(RAM_REQ_VALID), .RAM_REQ(RAM_REQ),
   .RAM_ACK(RAM_ACK), .RAM_DENIED(RAM_DENIED), .SECURED(SECURED),
   .STACK_PTR_INIT(STACK_PTR_INIT));
`default_nettype wire
